// ---- core/rmaa_map.svh ----
/*
 * Constants of the ratemeter alarm annunciator: timing, scale and display codes.
 * Assumes the includer uses these macros as widths or as sized values.
 */
// Overview of operation
// [R1] A rate above the high setpoint flashes the high lamp until it is acknowledged.
// [R2] A rate above the warning setpoint flashes the warning lamp until it is acknowledged.
// [R3] The failure lamp is lit steadily while the failure lasts and clears on its own.
// [R4] The range lamp is lit steadily while over or under range and clears on return.
// [R5] The range lamp never flashes and follows only the present range condition.
// [R6] An acknowledge turns each flashing lamp whose condition remains into a steady one.
// [R7] An acknowledged alarm's relay returns only once the rate falls below its setpoint.
// [R8] With the auto-reset jumper fitted, alarms clear unacknowledged once below setpoint.
// [R9] The remote acknowledge input acts exactly like the front acknowledge button.
// [R10] The bargraph is green with no alarm, amber on warning and red on high alarm.
// [R11] The bargraph lights three segments per decade from 0.01 upward, 24 in all.
// [R12] Check source and its lamp are on only while the check button is held.
// [R13] Holding a setpoint button shows that setpoint instead of the measured rate.
// [R14] The display shows three digits with a floating point and one of three units.
// [R15] Over range is flagged and never shown as an on-scale reading.
// [R16] The detector toggles its output once per event, so each edge is one count.
// [R17] Alarm relays are energised when quiet and released on alarm, for fail-safe action.
`ifndef RMAA_MAP_SVH
`define RMAA_MAP_SVH

`define RMAA_CLK_MHZ 200
`define RMAA_BLINK_HALF_MS 250
`define RMAA_BLINK_CYC (`RMAA_BLINK_HALF_MS * `RMAA_CLK_MHZ * 1000)

`define RMAA_SEG_N 24
`define RMAA_SEG_PER_DEC 5'd3
`define RMAA_SEG_STEP1 10'd200
`define RMAA_SEG_STEP2 10'd500
`define RMAA_NORM_MANT 10'd100
`define RMAA_OVR_EXP 4'd7
`define RMAA_P_OFS 5'sd2

`define RMAA_BCD_DASH 4'hf
`define RMAA_BCD_ZERO 4'h0

`endif

// ---- core/rmaa_pkg.sv ----
/*
 * Types of the ratemeter alarm annunciator.
 * Assumes rmaa_map.svh supplies the numeric constants.
 */
package rmaa_pkg;

    // value in mR/h = mant * 10^expo * 1e-4, mant 100..999 whenever expo > 0
    typedef struct packed {
        logic [9:0] mant;
        logic [3:0] expo;
    } rmaa_rate_s;

    typedef struct packed {
        logic [3:0] dig2;
        logic [3:0] dig1;
        logic [3:0] dig0;
        logic [1:0] dp;
        logic [2:0] unit;
    } rmaa_disp_s;

    typedef struct packed {
        logic high;
        logic warn;
        logic fail;
        logic range;
        logic chk;
    } rmaa_lamp_s;

    typedef struct packed {
        logic high;
        logic warn;
        logic fail;
    } rmaa_relay_s;

    typedef enum logic [2:0] {
        RMAA_ST_IDLE = 3'b001,
        RMAA_ST_FLASH = 3'b010,
        RMAA_ST_STEADY = 3'b100
    } rmaa_alm_e;

    typedef enum logic [2:0] {
        RMAA_COL_GREEN = 3'b001,
        RMAA_COL_AMBER = 3'b010,
        RMAA_COL_RED = 3'b100
    } rmaa_color_e;

    typedef enum logic [2:0] {
        RMAA_UNIT_MR = 3'b001,
        RMAA_UNIT_R = 3'b010,
        RMAA_UNIT_KR = 3'b100
    } rmaa_unit_e;

endpackage

// ---- core/rmaa_annunciator.sv ----
/*
 * Alarm annunciation and display control of the digital_ratemeter.
 * Assumes rate, setpoints, failure and saturation come from logic on sys_clk_i,
 * and that buttons, jumper, remote acknowledge and detector line are raw pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rmaa_map.svh"

module rmaa_annunciator #(
    parameter int unsigned BLINK_CYC = `RMAA_BLINK_CYC,
    parameter int unsigned SEG_N = `RMAA_SEG_N
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic det_pulse_i,
    input wire logic ack_btn_i,
    input wire logic ack_remote_i,
    input wire logic chk_btn_i,
    input wire logic hi_btn_i,
    input wire logic warn_btn_i,
    input wire logic auto_rst_jmp_i,
    input wire logic fail_cond_i,
    input wire logic det_sat_i,
    input wire rmaa_pkg::rmaa_rate_s rate_i,
    input wire rmaa_pkg::rmaa_rate_s hi_sp_i,
    input wire rmaa_pkg::rmaa_rate_s warn_sp_i,
    output logic count_pulse_o,
    output rmaa_pkg::rmaa_lamp_s lamps_o,
    output rmaa_pkg::rmaa_relay_s relay_o,
    output logic chk_src_o,
    output rmaa_pkg::rmaa_disp_s disp_o,
    output logic [SEG_N-1:0] bar_o,
    output rmaa_pkg::rmaa_color_e bar_color_o
);
    import rmaa_pkg::*;

    localparam int unsigned NS = 7;
    localparam int unsigned P_JMP = 0;
    localparam int unsigned P_WARN = 1;
    localparam int unsigned P_HI = 2;
    localparam int unsigned P_CHK = 3;
    localparam int unsigned P_ACKR = 4;
    localparam int unsigned P_ACKB = 5;
    localparam int unsigned P_DET = 6;
    localparam int unsigned A_HI = 0;
    localparam int unsigned A_WARN = 1;
    localparam rmaa_rate_s OVR_RATE = '{mant: `RMAA_NORM_MANT, expo: `RMAA_OVR_EXP};

    function automatic logic rate_gt(input rmaa_rate_s a, input rmaa_rate_s b);
        rate_gt = (a.expo > b.expo) || ((a.expo == b.expo) && (a.mant > b.mant));
    endfunction

    // three digits, point position and unit of a rate
    function automatic rmaa_disp_s fmt(input rmaa_rate_s r);
        rmaa_disp_s f;
        logic [3:0] d2;
        logic [3:0] d1;
        logic [3:0] d0;
        logic signed [4:0] p;
        d2 = 4'((r.mant / 10'd100) % 10'd10);
        d1 = 4'((r.mant / 10'd10) % 10'd10);
        d0 = 4'(r.mant % 10'd10);
        p = $signed({1'b0, r.expo}) - `RMAA_P_OFS;
        f = '{dig2: d2, dig1: d1, dig0: d0, dp: 2'd0, unit: RMAA_UNIT_MR};
        if (p == -5'sd1) begin
            f.dig2 = `RMAA_BCD_ZERO;
            f.dig1 = d2;
            f.dig0 = d1;
        end else if (p < -5'sd1) begin
            f.dig2 = `RMAA_BCD_ZERO;
            f.dig1 = `RMAA_BCD_ZERO;
            f.dig0 = d2;
        end else if (p < 5'sd3) begin
            f.dp = 2'(p);
        end else if (p < 5'sd6) begin
            f.dp = 2'(p - 5'sd3);
            f.unit = RMAA_UNIT_R;
        end else begin
            f.dp = 2'(p - 5'sd6);
            f.unit = RMAA_UNIT_KR;
        end
        return f;
    endfunction

    // pin synchronisers and edge memory
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] meta_q;
    logic [NS-1:0] meta_d;
    logic [NS-1:0] sync_q;
    logic [NS-1:0] sync_d;
    logic [NS-1:0] prev_q;
    logic [NS-1:0] prev_d;

    assign pin_raw = {det_pulse_i, ack_btn_i, ack_remote_i, chk_btn_i,
                      hi_btn_i, warn_btn_i, auto_rst_jmp_i};

    always_comb begin
        meta_d = pin_raw;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    logic ack_pulse;
    logic det_edge;
    logic auto_rst;

    // either acknowledge source gives the same one-cycle press
    assign ack_pulse = (sync_q[P_ACKB] & ~prev_q[P_ACKB])
                     | (sync_q[P_ACKR] & ~prev_q[P_ACKR]); // [R9]
    // the detector line toggles once per event, so both edges count
    assign det_edge = sync_q[P_DET] ^ prev_q[P_DET]; // [R16]
    assign auto_rst = sync_q[P_JMP];

    // flash phase generator
    logic [31:0] blink_cnt_q;
    logic [31:0] blink_cnt_d;
    logic blink_q;
    logic blink_d;

    always_comb begin
        blink_cnt_d = blink_cnt_q + 32'd1;
        blink_d = blink_q;
        if (blink_cnt_q >= BLINK_CYC - 32'd1) begin
            blink_cnt_d = '0;
            blink_d = ~blink_q;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end else begin
            blink_cnt_q <= blink_cnt_d;
            blink_q <= blink_d;
        end
    end

    // high and warning alarm state machines
    logic [1:0] cond;
    rmaa_alm_e st_q [2];
    rmaa_alm_e st_d [2];

    assign cond[A_HI] = rate_gt(rate_i, hi_sp_i); // [R1]
    assign cond[A_WARN] = rate_gt(rate_i, warn_sp_i); // [R2]

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            st_d[i] = st_q[i];
            unique case (st_q[i])
                RMAA_ST_IDLE: begin
                    if (cond[i]) begin
                        st_d[i] = RMAA_ST_FLASH; // [R1] [R2]
                    end
                end
                RMAA_ST_FLASH: begin
                    if (!cond[i] && (ack_pulse || auto_rst)) begin
                        st_d[i] = RMAA_ST_IDLE; // [R8]
                    end else if (ack_pulse) begin
                        st_d[i] = RMAA_ST_STEADY; // [R6]
                    end
                end
                RMAA_ST_STEADY: begin
                    if (!cond[i]) begin
                        st_d[i] = RMAA_ST_IDLE; // [R7]
                    end
                end
                default: begin
                    st_d[i] = RMAA_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q[0] <= RMAA_ST_IDLE;
            st_q[1] <= RMAA_ST_IDLE;
        end else begin
            st_q[0] <= st_d[0];
            st_q[1] <= st_d[1];
        end
    end

    // range, display and bargraph
    logic over_rng;
    logic under_rng;
    logic [4:0] seg_n;
    rmaa_disp_s disp_d;
    logic [SEG_N-1:0] bar_d;
    rmaa_color_e color_d;

    assign over_rng = rate_gt(rate_i, OVR_RATE) | det_sat_i; // [R15]
    assign under_rng = (rate_i.expo == 4'd0) && (rate_i.mant < `RMAA_NORM_MANT);

    always_comb begin
        seg_n = `RMAA_SEG_PER_DEC * {1'b0, rate_i.expo} + 5'd1;
        if (rate_i.mant >= `RMAA_SEG_STEP1) begin
            seg_n = seg_n + 5'd1;
        end
        if (rate_i.mant >= `RMAA_SEG_STEP2) begin
            seg_n = seg_n + 5'd1;
        end
        if (under_rng) begin
            seg_n = 5'd0;
        end
        for (int k = 0; k < SEG_N; k++) begin
            bar_d[k] = (5'(k) < seg_n) || (over_rng && 5'(k) == 5'(SEG_N - 1)); // [R11]
        end
    end

    always_comb begin
        if (sync_q[P_HI]) begin
            disp_d = fmt(hi_sp_i); // [R13]
        end else if (sync_q[P_WARN]) begin
            disp_d = fmt(warn_sp_i); // [R13]
        end else begin
            disp_d = fmt(rate_i); // [R14]
            if (over_rng) begin
                disp_d.dig2 = `RMAA_BCD_DASH; // [R15]
                disp_d.dig1 = `RMAA_BCD_DASH;
                disp_d.dig0 = `RMAA_BCD_DASH;
            end
        end
    end

    always_comb begin
        if (st_q[A_HI] != RMAA_ST_IDLE) begin
            color_d = RMAA_COL_RED; // [R10]
        end else if (st_q[A_WARN] != RMAA_ST_IDLE) begin
            color_d = RMAA_COL_AMBER; // [R10]
        end else begin
            color_d = RMAA_COL_GREEN; // [R10]
        end
    end

    // registered outputs
    rmaa_lamp_s lamps_d;
    rmaa_relay_s relay_d;

    always_comb begin
        lamps_d.high = (st_q[A_HI] == RMAA_ST_STEADY)
                     | ((st_q[A_HI] == RMAA_ST_FLASH) & blink_q); // [R1] [R6]
        lamps_d.warn = (st_q[A_WARN] == RMAA_ST_STEADY)
                     | ((st_q[A_WARN] == RMAA_ST_FLASH) & blink_q); // [R2] [R6]
        lamps_d.fail = fail_cond_i; // [R3]
        lamps_d.range = over_rng | under_rng; // [R4] [R5]
        lamps_d.chk = sync_q[P_CHK]; // [R12]
        relay_d.high = (st_q[A_HI] == RMAA_ST_IDLE); // [R17] [R7]
        relay_d.warn = (st_q[A_WARN] == RMAA_ST_IDLE); // [R17] [R7]
        relay_d.fail = ~fail_cond_i; // [R17]
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_pulse_o <= 1'b0;
            lamps_o <= '0;
            relay_o <= '0;
            chk_src_o <= 1'b0;
            disp_o <= '0;
            bar_o <= '0;
            bar_color_o <= RMAA_COL_GREEN;
        end else begin
            count_pulse_o <= det_edge;
            lamps_o <= lamps_d;
            relay_o <= relay_d;
            chk_src_o <= sync_q[P_CHK]; // [R12]
            disp_o <= disp_d;
            bar_o <= bar_d;
            bar_color_o <= color_d;
        end
    end

endmodule // rmaa_annunciator

`default_nettype wire

// ---- tb/rmaa_det_model.sv ----
/* detector preamplifier model: square wave toggling once per event.
   assumes the bench raises hit_i for one cycle per event */
`timescale 1ns/1ps
`default_nettype none
module rmaa_det_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic hit_i,
    output logic det_o
);
    logic det_q, det_d;
    always_comb det_d = hit_i ? !det_q : det_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) det_q <= 1'b0;
        else det_q <= det_d;
    end
    assign det_o = det_q;
endmodule // rmaa_det_model
`default_nettype wire

// ---- tb/rmaa_annunciator_sva.sv ----
/* assertions on the annunciator ports.
   assumes a bind from the bench top onto the design */
`timescale 1ns/1ps
`default_nettype none
`include "rmaa_map.svh"
module rmaa_annunciator_sva #(
    parameter int unsigned BLINK_CYC = 4,
    parameter int unsigned SEG_N = 24
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic det_pulse_i,
    input wire logic ack_btn_i,
    input wire logic ack_remote_i,
    input wire logic chk_btn_i,
    input wire logic hi_btn_i,
    input wire logic warn_btn_i,
    input wire logic auto_rst_jmp_i,
    input wire logic fail_cond_i,
    input wire logic det_sat_i,
    input wire rmaa_pkg::rmaa_rate_s rate_i,
    input wire rmaa_pkg::rmaa_rate_s hi_sp_i,
    input wire rmaa_pkg::rmaa_rate_s warn_sp_i,
    input wire logic count_pulse_o,
    input wire rmaa_pkg::rmaa_lamp_s lamps_o,
    input wire rmaa_pkg::rmaa_relay_s relay_o,
    input wire logic chk_src_o,
    input wire rmaa_pkg::rmaa_disp_s disp_o,
    input wire logic [SEG_N-1:0] bar_o,
    input wire rmaa_pkg::rmaa_color_e bar_color_o
);
    import rmaa_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic hi_above = rate_i.expo > hi_sp_i.expo ||
        (rate_i.expo == hi_sp_i.expo && rate_i.mant > hi_sp_i.mant);
    a_chk_on: assert property (chk_btn_i [*5] |-> chk_src_o && lamps_o.chk)
        else $error("check source not on");
    a_chk_off: assert property (!chk_btn_i [*5] |-> !chk_src_o && !lamps_o.chk)
        else $error("check source not off");
    a_fail_track: assert property ($past(rst_n_i) |-> lamps_o.fail == $past(fail_cond_i)
        && relay_o.fail == !lamps_o.fail) else $error("fail lamp or relay wrong");
    a_range_under: assert property ((rate_i.expo == 4'h0 && rate_i.mant < 10'd100) [*2]
        |-> lamps_o.range && bar_o == '0) else $error("under range not shown");
    a_over_dash: assert property ((det_sat_i && !hi_btn_i && !warn_btn_i) [*5]
        |-> lamps_o.range && disp_o.dig2 == `RMAA_BCD_DASH && bar_o[SEG_N-1])
        else $error("over range shown on scale");
    a_relay_idle: assert property (relay_o.high |-> !lamps_o.high)
        else $error("high lamp lit with relay energised");
    a_color_red: assert property ($past(rst_n_i) && !relay_o.high |->
        bar_color_o == RMAA_COL_RED) else $error("bar not red");
    a_color_amber: assert property (relay_o.high && !relay_o.warn |->
        bar_color_o == RMAA_COL_AMBER) else $error("bar not amber");
    a_color_green: assert property (relay_o.high && relay_o.warn |->
        bar_color_o == RMAA_COL_GREEN) else $error("bar not green");
    a_high_trip: assert property (hi_above ##1 hi_above |=> !relay_o.high)
        else $error("high relay not tripped");
    a_high_hold: assert property ($past(rst_n_i, 3) && $rose(relay_o.high)
        |-> !$past(hi_above, 2)) else $error("high relay reset above setpoint");
    a_pulse_one: assert property (count_pulse_o |=> !count_pulse_o)
        else $error("count pulse too long");
    a_pulse_edge: assert property ($changed(det_pulse_i) |-> ##[2:5] count_pulse_o)
        else $error("detector edge not counted");
    cover property (!relay_o.high ##1 relay_o.high);
    cover property (lamps_o.range);
    cover property (chk_src_o);
endmodule // rmaa_annunciator_sva
`default_nettype wire

// ---- tb/rmaa_annunciator_tb.sv ----
/* self-checking bench of the annunciator.
   assumes the design, the detector model and the checker are compiled first */
`timescale 1ns/1ps
`default_nettype none
module rmaa_annunciator_tb;
    import rmaa_pkg::*;
    logic sys_clk_i, rst_n_i, ack_btn_i, ack_remote_i, chk_btn_i, hi_btn_i, warn_btn_i;
    logic auto_rst_jmp_i, fail_cond_i, det_sat_i, hit, det_pulse_i, count_pulse_o, chk_src_o;
    rmaa_rate_s rate_i, hi_sp_i, warn_sp_i, r;
    rmaa_lamp_s lamps_o;
    rmaa_relay_s relay_o;
    rmaa_disp_s disp_o;
    logic [23:0] bar_o;
    rmaa_color_e bar_color_o;
    int fails, checks_done, npulse;
    logic s0, s1;
    rmaa_det_model u_det (.sys_clk_i, .rst_n_i, .hit_i(hit), .det_o(det_pulse_i));
    rmaa_annunciator #(.BLINK_CYC(4), .SEG_N(24)) uut (.sys_clk_i, .rst_n_i, .det_pulse_i,
        .ack_btn_i, .ack_remote_i, .chk_btn_i, .hi_btn_i, .warn_btn_i, .auto_rst_jmp_i,
        .fail_cond_i, .det_sat_i, .rate_i, .hi_sp_i, .warn_sp_i, .count_pulse_o, .lamps_o,
        .relay_o, .chk_src_o, .disp_o, .bar_o, .bar_color_o);
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    always @(negedge sys_clk_i) if (count_pulse_o === 1'b1) npulse++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic flash(input bit hi);
        {s0, s1} = 2'b00;
        repeat (24) begin
            @(negedge sys_clk_i);
            if ((hi ? lamps_o.high : lamps_o.warn) === 1'b1) s1 = 1'b1;
            else s0 = 1'b1;
        end
    endtask
    task automatic press(input bit rem);
        if (rem) ack_remote_i = 1'b1;
        else ack_btn_i = 1'b1;
        cyc(3);
        {ack_btn_i, ack_remote_i} = 2'b00;
        cyc(6);
    endtask
    function automatic logic [23:0] ebar(rmaa_rate_s x);
        return (24'd1 << (3 * x.expo + 1 + (x.mant >= 200) + (x.mant >= 500))) - 24'd1;
    endfunction
    function automatic rmaa_disp_s edisp(rmaa_rate_s x);
        int p;
        rmaa_disp_s d;
        p = x.expo - 2;
        d.dig2 = 4'(x.mant / 100);
        d.dig1 = 4'(x.mant / 10 % 10);
        d.dig0 = 4'(x.mant % 10);
        if (p < 0) {d.dig2, d.dig1, d.dig0} = {4'h0, d.dig2, d.dig1};
        d.dp = 2'(p < 0 ? 0 : p % 3);
        d.unit = p < 3 ? RMAA_UNIT_MR : (p < 6 ? RMAA_UNIT_R : RMAA_UNIT_KR);
        return d;
    endfunction
    task automatic test_done;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done;
    end
    initial begin
        {ack_btn_i, ack_remote_i, chk_btn_i, hi_btn_i, warn_btn_i} = '0;
        {auto_rst_jmp_i, fail_cond_i, det_sat_i, hit, rst_n_i} = '0;
        hi_sp_i = '{10'd500, 4'd4};
        warn_sp_i = '{10'd200, 4'd4};
        rate_i = '{10'd150, 4'd3};
        void'($urandom(32'h3ab0));
        cyc(10);
        rst_n_i = 1'b1;
        cyc(4);
        rate_i = '{10'd600, 4'd4};
        flash(1);
        chk(s0 & s1, 1, "high not flashing");
        flash(0);
        chk(s0 & s1, 1, "warn not flashing");
        chk(relay_o, 3'b001, "relays not tripped");
        chk(bar_color_o, RMAA_COL_RED, "colour on high");
        press(0);
        flash(1);
        chk({s0, s1}, 2'b01, "high not steady");
        chk(relay_o, 3'b001, "relay released above");
        rate_i = '{10'd150, 4'd4};
        cyc(4);
        chk({relay_o, lamps_o}, 8'he0, "alarms not cleared");
        chk(bar_color_o, RMAA_COL_GREEN, "colour quiet");
        $display("test high_ack done");
        rate_i = '{10'd250, 4'd4};
        cyc(6);
        chk(bar_color_o, RMAA_COL_AMBER, "colour on warn");
        rate_i = '{10'd150, 4'd4};
        flash(0);
        chk({s0, s1}, 2'b11, "warn cleared without ack");
        press(1);
        chk(relay_o.warn, 1, "remote ack ignored");
        auto_rst_jmp_i = 1'b1;
        rate_i = '{10'd600, 4'd4};
        cyc(6);
        rate_i = '{10'd150, 4'd4};
        cyc(5);
        chk(relay_o, 3'b111, "auto reset failed");
        auto_rst_jmp_i = 1'b0;
        $display("test remote_auto done");
        repeat (20) begin
            fail_cond_i = 1'($urandom);
            cyc(3);
            chk({lamps_o.fail, relay_o.fail}, {fail_cond_i, !fail_cond_i}, "fail");
        end
        fail_cond_i = 1'b0;
        rate_i = '{10'd50, 4'd0};
        cyc(4);
        chk({lamps_o.range, bar_o}, 25'h1000000, "under range");
        rate_i = '{10'd300, 4'd3};
        cyc(4);
        chk(lamps_o.range, 0, "range stuck");
        det_sat_i = 1'b1;
        cyc(6);
        chk({lamps_o.range, disp_o.dig2, bar_o[23]}, 6'h3f, "over range");
        det_sat_i = 1'b0;
        chk_btn_i = 1'b1;
        cyc(6);
        chk({chk_src_o, lamps_o.chk}, 2'b11, "check on");
        chk_btn_i = 1'b0;
        cyc(6);
        chk({chk_src_o, lamps_o.chk}, 2'b00, "check off");
        $display("test fail_range_check done");
        npulse = 0;
        repeat (40) begin
            r = '{10'(100 + $urandom % 900), 4'(1 + $urandom % 6)};
            rate_i = r;
            hit = 1'b1;
            cyc(1);
            hit = 1'b0;
            cyc(5);
            chk(disp_o, edisp(r), "display");
            chk(bar_o, ebar(r), "bargraph");
        end
        chk(npulse, 40, "count pulses");
        hi_btn_i = 1'b1;
        warn_btn_i = 1'b1;
        cyc(6);
        chk(disp_o, edisp(hi_sp_i), "high setpoint shown");
        hi_btn_i = 1'b0;
        cyc(6);
        chk(disp_o, edisp(warn_sp_i), "warn setpoint shown");
        $display("test display done");
        test_done;
    end
endmodule // rmaa_annunciator_tb
bind rmaa_annunciator rmaa_annunciator_sva #(.BLINK_CYC(BLINK_CYC), .SEG_N(SEG_N)) u_sva (
    .sys_clk_i, .rst_n_i, .det_pulse_i, .ack_btn_i, .ack_remote_i, .chk_btn_i, .hi_btn_i,
    .warn_btn_i, .auto_rst_jmp_i, .fail_cond_i, .det_sat_i, .rate_i, .hi_sp_i, .warn_sp_i,
    .count_pulse_o, .lamps_o, .relay_o, .chk_src_o, .disp_o, .bar_o, .bar_color_o);
`default_nettype wire
